// [core/psi_consts.svh]
// Offsets, field positions, reset values and timing counts of the sensor timing block.
`ifndef PSI_CONSTS_SVH
`define PSI_CONSTS_SVH
`define PSI_CLK_NS        4
`define PSI_TICK_NS       500
`define PSI_TICK_CYC      (`PSI_TICK_NS / `PSI_CLK_NS)
`define PSI_FREE_RUN_US   228
`define PSI_FREE_RUN_TCK  (`PSI_FREE_RUN_US * 1000 / `PSI_TICK_NS)
`define PSI_T_INIT_US     5000
`define PSI_T_ST_US       96000
`define PSI_T_P12_US      112500
`define PSI_ENTRY_EDGES   8
`define PSI_OFS_CTRL      8'h00
`define PSI_OFS_SLOT      8'h04
`define PSI_OFS_STATUS    8'h08
`define PSI_OFS_IRQ_STAT  8'h0c
`define PSI_OFS_IRQ_MASK  8'h10
`define PSI_OFS_SAMPLE    8'h14
`define PSI_CTRL_RST      8'h10
`define PSI_SLOT_RST      32'h01f4_0000
`define PSI_MODE_NORMAL   2'h0
`define PSI_F_FREE_RUN    2
`define PSI_F_SAMPLE_SYNC 3
`define PSI_F_USER_LOCK   7
`define PSI_IRQ_READY     0
`define PSI_IRQ_DEFECT    1
`define PSI_IRQ_PROG      2
`define PSI_IRQ_RETRY     3
`endif

// [core/psi_div.sv]
// Divider that yields the half-microsecond slot tick enable.
`timescale 1ns/1ps
`default_nettype none
`include "psi_consts.svh"
module psi_div #(
    parameter int DIV = `PSI_TICK_CYC
) (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    output logic      tick
);
    logic [7:0] cnt_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 8'h00;
            tick  <= 1'b0;
        end else if (cnt_q == 8'(DIV - 1)) begin
            cnt_q <= 8'h00;
            tick  <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            tick  <= 1'b0;
        end
    end
endmodule : psi_div
`default_nettype wire

// [core/psi_pkg.sv]
// Types shared by the sensor timing block.
package psi_pkg;
    typedef enum logic [2:0] {
        PSI_PH1  = 3'b000,
        PSI_PH2  = 3'b001,
        PSI_PH3  = 3'b010,
        PSI_RUN  = 3'b011,
        PSI_FAIL = 3'b100,
        PSI_PROG = 3'b101
    } psi_state_t;
    typedef enum logic [1:0] {
        PSI_MSG_BUSY   = 2'b00,
        PSI_MSG_READY  = 2'b01,
        PSI_MSG_DEFECT = 2'b10,
        PSI_MSG_DATA   = 2'b11
    } psi_msg_t;
endpackage : psi_pkg

// [core/psi_slot.sv]
// Sync edge detector, first slot delay timer and free-running period timer.
`timescale 1ns/1ps
`default_nettype none
`include "psi_consts.svh"
module psi_slot #(
    parameter int FREE_TICKS = `PSI_FREE_RUN_TCK
) (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic tick,
    psi_trig_if.tmr   trg
);
    logic       prev_q;
    logic       armed_q;
    logic [9:0] cnt_q;
    logic [9:0] free_q;
    logic       edge_w;

    assign edge_w = trg.sync_level & ~prev_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q        <= 1'b0;
            trg.trig_edge <= 1'b0;
        end else begin
            prev_q        <= trg.sync_level;
            trg.trig_edge <= edge_w;
        end
    end

    // The counter restarts on every edge outside free-running so a late pulse never inherits stale time.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            armed_q  <= 1'b0;
            cnt_q    <= 10'h000;
            trg.fire <= 1'b0;
        end else if (edge_w && !trg.free_running_select_en) begin
            cnt_q    <= 10'h000;
            armed_q  <= (trg.slot_delay != 10'h000);
            trg.fire <= (trg.slot_delay == 10'h000);
        end else if (armed_q && tick) begin
            cnt_q    <= cnt_q + 10'h001;
            armed_q  <= (cnt_q + 10'h001 != trg.slot_delay);
            trg.fire <= (cnt_q + 10'h001 == trg.slot_delay);
        end else begin
            trg.fire <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            free_q        <= 10'h000;
            trg.free_tick <= 1'b0;
        end else if (!trg.free_running_select_en) begin
            free_q        <= 10'h000;
            trg.free_tick <= 1'b0;
        end else if (tick) begin
            free_q        <= (free_q == 10'(FREE_TICKS - 1)) ? 10'h000 : free_q + 10'h001;
            trg.free_tick <= (free_q == 10'(FREE_TICKS - 1));
        end else begin
            trg.free_tick <= 1'b0;
        end
    end
endmodule : psi_slot
`default_nettype wire

// [core/psi_top.sv]
// Initialization phase 3 sequencing and normal mode sample timing with an APB register file.
// Operation
// - In phase 3 the block finishes self-test, sending busy messages then one ready or defect.
// - A failed self-test is rerun, up to the programmed repeat limit.
// - Repetition stops at the first passing self-test sequence.
// - Phase 3 lasts the sync period times (roundup(remaining time / period) + 2).
// - 10-bit synchronous, one repetition, gives 170 busy plus 1 final message (85.50 ms).
// - 8-bit synchronous, one repetition, gives 138 busy plus 1 final message (69.50 ms).
// - Asynchronous operation needs normal mode, free-running set and a zero first slot delay.
// - Asynchronous operation sends at the fixed free-running period and ignores sync pulses.
// - Sync pulses are still watched in phase 1 to decode the programming entry command.
// - Programming mode is entered on that command only while the user lock is clear.
// - Normal mode with the sample select bit clear selects simultaneous sampling.
// - Simultaneous sampling latches at the sync edge and sends after the first slot delay.
// - Normal mode with the sample select bit set selects synchronous sampling.
// - Synchronous sampling latches and sends at the moment the first slot delay expires.
// - A passed self-test leads on into normal mode data transmission.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "psi_consts.svh"
module psi_top #(
    parameter logic [23:0] T_INIT_US   = 24'(`PSI_T_INIT_US),
    parameter logic [23:0] T_ST_US     = 24'(`PSI_T_ST_US),
    parameter logic [23:0] T_P12_US    = 24'(`PSI_T_P12_US),
    parameter int          ENTRY_EDGES = `PSI_ENTRY_EDGES
) (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sync_in,
    input  wire logic [15:0] accel_in,
    input  wire logic        phase1_end,
    input  wire logic        phase2_end,
    input  wire logic        st_done,
    input  wire logic        st_pass,
    output logic             st_start,
    output logic             tx_start,
    output logic [1:0]       tx_kind,
    output logic [15:0]      tx_data,
    output logic             prog_mode,
    output logic             irq
);
    psi_pkg::psi_state_t state_q;
    logic [7:0]  ctrl_q;
    logic [31:0] slot_q;
    logic [3:0]  irq_stat_q;
    logic [3:0]  irq_mask_q;
    logic [15:0] samp_q;
    logic [15:0] busy_cnt_q;
    logic [2:0]  att_q;
    logic        st_ok_q;
    logic        st_bad_q;
    logic [23:0] acc_q;
    logic [7:0]  edges_q;
    logic        tick;
    logic        wr_en;
    logic        free_running_select_en;
    logic        slot_ev;
    logic [23:0] total_us;
    logic [23:0] need_us;
    logic [23:0] period_us;
    logic        p3_final;
    logic        retry;
    logic        entry_hit;
    logic [3:0]  irq_set;
    logic [31:0] rd_w;
    logic        map_w;

    psi_trig_if trg ();

    psi_div u_div (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .tick    (tick)
    );

    psi_slot u_slot (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .tick    (tick),
        .trg     (trg)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decode.
    assign free_running_select_en = (ctrl_q[1:0] == `PSI_MODE_NORMAL) && ctrl_q[`PSI_F_FREE_RUN]
                      && (slot_q[9:0] == 10'h000);
    assign trg.sync_level = sync_in;
    assign trg.slot_delay = slot_q[9:0];
    assign trg.free_running_select_en   = free_running_select_en;
    // The slot event paces every message: the free-running timer or the delayed sync edge.
    assign slot_ev = free_running_select_en ? trg.free_tick : trg.fire;

    ////////////////////////////////////////////////////////////////////////////////
    // Phase 3 length from the remaining self-test time and the message period.
    assign total_us  = T_INIT_US + T_ST_US * 24'({1'b0, ctrl_q[6:4]} + 4'h1);
    assign need_us   = (total_us > T_P12_US) ? total_us - T_P12_US : 24'h000000;
    assign period_us = free_running_select_en ? 24'(`PSI_FREE_RUN_US) : {14'h0000, slot_q[25:16]};
    // One busy message per period until the rounded-up need plus one more is covered.
    assign p3_final  = (acc_q >= need_us + period_us) && (st_ok_q || st_bad_q);
    assign retry     = st_done && !st_pass && !st_ok_q && (att_q < ctrl_q[6:4]);
    assign entry_hit = (state_q == psi_pkg::PSI_PH1) && trg.trig_edge
                       && (edges_q == 8'(ENTRY_EDGES - 1));

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= psi_pkg::PSI_PH1;
        end else begin
            case (state_q)
                psi_pkg::PSI_PH1: begin
                    if (entry_hit && !ctrl_q[`PSI_F_USER_LOCK]) begin
                        state_q <= psi_pkg::PSI_PROG;
                    end else if (phase1_end) begin
                        state_q <= psi_pkg::PSI_PH2;
                    end
                end
                psi_pkg::PSI_PH2: begin
                    if (phase2_end) begin
                        state_q <= psi_pkg::PSI_PH3;
                    end
                end
                psi_pkg::PSI_PH3: begin
                    if (slot_ev && p3_final) begin
                        state_q <= st_ok_q ? psi_pkg::PSI_RUN : psi_pkg::PSI_FAIL;
                    end
                end
                psi_pkg::PSI_RUN:  state_q <= psi_pkg::PSI_RUN;
                psi_pkg::PSI_FAIL: state_q <= psi_pkg::PSI_FAIL;
                psi_pkg::PSI_PROG: state_q <= psi_pkg::PSI_PROG;
                default:           state_q <= psi_pkg::PSI_PH1;
            endcase
        end
    end

    // Entry command edges are counted in phase 1 even when sync pulses are otherwise ignored.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            edges_q <= 8'h00;
        end else if (state_q == psi_pkg::PSI_PH1 && trg.trig_edge) begin
            edges_q <= edges_q + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_mode <= 1'b0;
        end else if (entry_hit && !ctrl_q[`PSI_F_USER_LOCK]) begin
            prog_mode <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Self-test repetition control.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_start <= 1'b0;
            att_q    <= 3'h0;
            st_ok_q  <= 1'b0;
            st_bad_q <= 1'b0;
        end else begin
            st_start <= (state_q == psi_pkg::PSI_PH1 && phase1_end) || retry;
            if (st_done && !st_ok_q && !st_bad_q) begin
                if (st_pass) begin
                    st_ok_q <= 1'b1;
                end else if (retry) begin
                    att_q <= att_q + 3'h1;
                end else begin
                    st_bad_q <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Message and sample transmission.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q      <= 24'h000000;
            busy_cnt_q <= 16'h0000;
        end else if (state_q == psi_pkg::PSI_PH3 && slot_ev && !p3_final) begin
            acc_q      <= acc_q + period_us;
            busy_cnt_q <= busy_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            samp_q <= 16'h0000;
        end else if (free_running_select_en ? trg.free_tick
                   : (ctrl_q[`PSI_F_SAMPLE_SYNC] ? trg.fire : trg.trig_edge)) begin
            samp_q <= accel_in;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_start <= 1'b0;
            tx_kind  <= psi_pkg::PSI_MSG_BUSY;
            tx_data  <= 16'h0000;
        end else begin
            tx_start <= 1'b0;
            if (slot_ev && state_q == psi_pkg::PSI_PH3) begin
                tx_start <= 1'b1;
                tx_data  <= 16'h0000;
                if (!p3_final) begin
                    tx_kind <= psi_pkg::PSI_MSG_BUSY;
                end else begin
                    tx_kind <= st_ok_q ? psi_pkg::PSI_MSG_READY : psi_pkg::PSI_MSG_DEFECT;
                end
            end else if (slot_ev && state_q == psi_pkg::PSI_RUN
                         && ctrl_q[1:0] == `PSI_MODE_NORMAL) begin
                tx_start <= 1'b1;
                tx_kind  <= psi_pkg::PSI_MSG_DATA;
                // Synchronous sampling sends the live sample, the others the held one.
                tx_data  <= (!free_running_select_en && ctrl_q[`PSI_F_SAMPLE_SYNC]) ? accel_in : samp_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait-free access phase, read data registered during setup.
    assign wr_en = psel && penable && pready && pwrite && !pslverr;
    assign map_w = (paddr == `PSI_OFS_CTRL) || (paddr == `PSI_OFS_SLOT)
                   || (paddr == `PSI_OFS_STATUS) || (paddr == `PSI_OFS_IRQ_STAT)
                   || (paddr == `PSI_OFS_IRQ_MASK) || (paddr == `PSI_OFS_SAMPLE);

    always_comb begin
        case (paddr)
            `PSI_OFS_CTRL:     rd_w = {24'h000000, ctrl_q};
            `PSI_OFS_SLOT:     rd_w = {6'h00, slot_q[25:16], 6'h00, slot_q[9:0]};
            `PSI_OFS_STATUS:   rd_w = {busy_cnt_q, 8'h00, st_bad_q, st_ok_q, att_q, state_q};
            `PSI_OFS_IRQ_STAT: rd_w = {28'h0000000, irq_stat_q};
            `PSI_OFS_IRQ_MASK: rd_w = {28'h0000000, irq_mask_q};
            `PSI_OFS_SAMPLE:   rd_w = {16'h0000, samp_q};
            default:           rd_w = 32'h00000000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !map_w;
            if (psel && !penable) begin
                prdata <= rd_w;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q     <= `PSI_CTRL_RST;
            slot_q     <= `PSI_SLOT_RST;
            irq_mask_q <= 4'h0;
        end else if (wr_en) begin
            if (paddr == `PSI_OFS_CTRL) begin
                ctrl_q <= pwdata[7:0];
            end
            if (paddr == `PSI_OFS_SLOT) begin
                slot_q <= {6'h00, pwdata[25:16], 6'h00, pwdata[9:0]};
            end
            if (paddr == `PSI_OFS_IRQ_MASK) begin
                irq_mask_q <= pwdata[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky event flags; a new event wins over a write-one clear in the same cycle.
    assign irq_set[`PSI_IRQ_READY]  = state_q == psi_pkg::PSI_PH3 && slot_ev && p3_final
                                      && st_ok_q;
    assign irq_set[`PSI_IRQ_DEFECT] = state_q == psi_pkg::PSI_PH3 && slot_ev && p3_final
                                      && !st_ok_q;
    assign irq_set[`PSI_IRQ_PROG]   = entry_hit && !ctrl_q[`PSI_F_USER_LOCK];
    assign irq_set[`PSI_IRQ_RETRY]  = retry;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_q <= 4'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((wr_en && paddr == `PSI_OFS_IRQ_STAT)
                          ? pwdata[3:0] : 4'h0)) | irq_set;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end
endmodule : psi_top
`default_nettype wire

// [core/psi_trig_if.sv]
// Trigger and slot timing signals between the top and the slot timer.
`timescale 1ns/1ps
`default_nettype none
interface psi_trig_if;
    logic       sync_level;
    logic [9:0] slot_delay;
    logic       free_running_select_en;
    logic       trig_edge;
    logic       fire;
    logic       free_tick;
    modport ctl (output sync_level, output slot_delay, output free_running_select_en,
                 input trig_edge, input fire, input free_tick);
    modport tmr (input sync_level, input slot_delay, input free_running_select_en,
                 output trig_edge, output fire, output free_tick);
endinterface : psi_trig_if
`default_nettype wire

// [tb/psi_sync_model.sv]
// Receiver model that issues periodic sync pulses.
`timescale 1ns/1ps
`default_nettype none
module psi_sync_model #(
    parameter int PERIOD = 1500,
    parameter int HIGH   = 50
) (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic run,
    output var logic  sync_level
);
    int cnt;
    // A started pulse always completes its period, so no runt edge is ever produced.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
            sync_level <= 1'b0;
        end else begin
            if (run || cnt != 0) begin
                cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            end
            sync_level <= (cnt < HIGH) && (run || cnt != 0);
        end
    end
endmodule : psi_sync_model
`default_nettype wire

// [tb/psi_top_assertions.sv]
// Port-level checker for the sensor timing block.
`timescale 1ns/1ps
`default_nettype none
module psi_top_assertions (
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        st_done,
    input wire logic        st_pass,
    input wire logic        st_start,
    input wire logic        tx_start,
    input wire logic [1:0]  tx_kind,
    input wire logic [15:0] tx_data,
    input wire logic        prog_mode,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////////////
    property p_ready_next;     psel && !penable |=> pready; endproperty
    property p_ready_cause;    pready |-> $past(psel) && !$past(penable); endproperty
    property p_setup_idle;     psel && !penable |-> !pready; endproperty
    property p_err_ready;      pslverr |-> pready; endproperty
    property p_rdata_hold;     pready |=> $stable(prdata); endproperty
    property p_tx_pulse;       tx_start |=> !tx_start; endproperty
    property p_tx_hold;        !tx_start |=> tx_start || ($stable(tx_data) && $stable(tx_kind));
    endproperty
    property p_st_pulse;       st_start |=> !st_start; endproperty
    property p_pass_stops;     st_done && st_pass |=> !st_start [*8]; endproperty
    property p_prog_sticky;    prog_mode |=> prog_mode; endproperty
    a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
    a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
    a_setup_idle: assert property (p_setup_idle) else $error("ready in setup cycle");
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    a_tx_pulse: assert property (p_tx_pulse) else $error("send pulse too long");
    a_tx_hold: assert property (p_tx_hold) else $error("message moved");
    a_st_pulse: assert property (p_st_pulse) else $error("self-test start too long");
    a_pass_stops: assert property (p_pass_stops) else $error("self-test rerun after pass");
    a_prog_sticky: assert property (p_prog_sticky) else $error("programming mode lost");
    c_data: cover property (tx_start && tx_kind == 2'h3);
    c_prog: cover property ($rose(prog_mode));
    c_irq: cover property ($rose(irq));
    c_err: cover property (pslverr);
endmodule : psi_top_assertions
bind psi_top psi_top_assertions u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .st_done(st_done),
    .st_pass(st_pass), .st_start(st_start), .tx_start(tx_start), .tx_kind(tx_kind),
    .tx_data(tx_data), .prog_mode(prog_mode), .irq(irq));
`default_nettype wire

// [tb/tb.sv]
// Self-checking testbench of the sensor timing block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        sys_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, sync_in, e, run = 1'b0;
    logic [15:0] accel_in = 16'h0, a, b;
    logic        phase1_end = 1'b0, phase2_end = 1'b0, st_done = 1'b0, st_pass = 1'b0;
    logic        st_start, tx_start, prog_mode, irq;
    logic [1:0]  tx_kind;
    logic [15:0] tx_data;
    int          n_mismatch = 0, total_checks = 0, c, d, busy;
    logic [31:0] tab [3][3] = '{'{32'h94, 32'h6_0000, 0}, '{32'h90, 32'h6_0000, 1},
                               '{32'h91, 32'h6_0004, 0}};
    psi_top #(.T_INIT_US(24'h0), .T_ST_US(24'h28), .T_P12_US(24'h0), .ENTRY_EDGES(8)) u_dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sync_in(sync_in), .accel_in(accel_in), .phase1_end(phase1_end),
        .phase2_end(phase2_end), .st_done(st_done), .st_pass(st_pass), .st_start(st_start),
        .tx_start(tx_start), .tx_kind(tx_kind), .tx_data(tx_data), .prog_mode(prog_mode),
        .irq(irq));
    psi_sync_model #(.PERIOD(1500)) u_ecu (.sys_clk(sys_clk), .arst_n(arst_n), .run(run),
        .sync_level(sync_in));
    always #2 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_word
    // Phase 3 sends one busy message per sync period until the needed time plus one more period is covered.
    function automatic int exp_busy(input int need, input int per);
        return (need + per - 1) / per + 1;
    endfunction : exp_busy
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= ad; pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (n > 20) begin
                chk_word(32'h0, 32'h1);
                stop_test();
            end
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Kinds of wait: 0 self-test start, 1 message start, 2 sync rising edge.
    task automatic wait_for(input int what, input int lim, output int cyc);
        logic prev, hit;
        prev = sync_in;
        cyc = 0;
        do begin
            @(posedge sys_clk);
            cyc++;
            hit = (what == 0) ? st_start === 1'b1 : (what == 1) ? tx_start === 1'b1 :
                  (sync_in === 1'b1 && prev === 1'b0);
            prev = sync_in;
            if (cyc > lim) begin
                chk_word(32'h0, 32'h1);
                stop_test();
            end
        end while (!hit);
    endtask : wait_for
    task automatic st_reply(input logic pass);
        repeat (5) @(posedge sys_clk);
        st_done <= 1'b1; st_pass <= pass;
        @(posedge sys_clk);
        st_done <= 1'b0; st_pass <= 1'b0;
    endtask : st_reply
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(74790));
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        apb(0, 8'h00, 0); chk_word(r, 32'h10);
        apb(0, 8'h04, 0); chk_word(r, 32'h01f4_0000);
        apb(0, 8'h10, 0); chk_word(r, 32'h0);
        apb(0, 8'h08, 0); chk_word(r, 32'h0);
        apb(1, 8'h40, 32'hffff_ffff); chk_word({31'h0, e}, 32'h1);
        apb(0, 8'h40, 0); chk_word({r[30:0], e}, 32'h1);
        apb(1, 8'h00, 32'h90); apb(1, 8'h04, 32'h0006_0004); apb(1, 8'h10, 32'hf);
        phase1_end <= 1'b1; @(posedge sys_clk); phase1_end <= 1'b0;
        wait_for(0, 50, c); st_reply(1'b0);
        wait_for(0, 50, c); st_reply(1'b1);
        phase2_end <= 1'b1; @(posedge sys_clk); phase2_end <= 1'b0;
        run <= 1'b1;
        busy = 0;
        do begin
            wait_for(1, 4000, c);
            if (tx_kind === 2'(psi_pkg::PSI_MSG_BUSY)) busy++;
        end while (tx_kind === 2'(psi_pkg::PSI_MSG_BUSY) && busy < 100);
        chk_word(busy, exp_busy(80, 6));
        chk_word({30'h0, tx_kind}, 32'(psi_pkg::PSI_MSG_READY));
        repeat (3) @(posedge sys_clk);
        chk_word({31'h0, irq}, 32'h1);
        apb(0, 8'h08, 0); chk_word({25'h0, r[6:0]}, 32'h4b);
        apb(0, 8'h0c, 0); chk_word(r, 32'h9);
        apb(1, 8'h0c, 32'h9); apb(0, 8'h0c, 0); chk_word(r, 32'h0);
        chk_word({31'h0, irq}, 32'h0);
        for (int s = 0; s < 6; s++) begin
            d = 2 + $urandom_range(6);
            apb(1, 8'h04, 32'h0006_0000 | d);
            apb(1, 8'h00, 32'h90 | ((s / 3) << 3));
            wait_for(1, 4000, c);
            a = 16'($urandom); b = ~a;
            accel_in <= a;
            wait_for(2, 4000, c);
            repeat (3) @(posedge sys_clk);
            accel_in <= b;
            wait_for(1, 1200, c);
            chk_word(32'(c + 3 >= (d - 1) * 125 && c + 3 <= (d + 1) * 125 + 5), 1);
            chk_word({30'h0, tx_kind}, 32'(psi_pkg::PSI_MSG_DATA));
            chk_word({16'h0, tx_data}, {16'h0, (s / 3) ? b : a});
        end
        foreach (tab[i]) begin
            apb(1, 8'h04, tab[i][1]); apb(1, 8'h00, tab[i][0]);
            wait_for(2, 4000, c);
            busy = 0;
            repeat (300) @(posedge sys_clk) if (tx_start === 1'b1) busy = 1;
            chk_word(busy, tab[i][2]);
        end
        run <= 1'b0;
        arst_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        apb(1, 8'h00, 32'h90);
        for (int g = 0; g < 2; g++) begin
            run <= 1'b1;
            repeat (8) wait_for(2, 4000, c);
            run <= 1'b0;
            repeat (20) @(posedge sys_clk);
            chk_word({31'h0, prog_mode}, g);
            // The locked attempt used up the edge count; reset restores it and clears the lock.
            if (g == 0) begin
                arst_n <= 1'b0;
                repeat (2) @(posedge sys_clk);
                arst_n <= 1'b1;
            end
        end
        chk_word({31'h0, irq}, 32'h0);
        apb(0, 8'h0c, 0); chk_word(r, 32'h4);
        apb(1, 8'h10, 32'h4);
        repeat (3) @(posedge sys_clk);
        chk_word({31'h0, irq}, 32'h1);
        stop_test();
    end
endmodule : tb
`default_nettype wire
